// File: rtl/plcps_pkg.sv
// Package of constants and types for the port latch clear and pull select block
package plcps_pkg;

   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int PORT_COUNT = 5;
   localparam int PORT_WIDTH = 16;
   localparam int ADDR_WIDTH = 12;
   localparam int DATA_WIDTH = 32;

   // ----------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------
   localparam logic [9:0] IDX_PULL_UP_SEL_A = 10'h020;
   localparam logic [9:0] IDX_PULL_UP_SEL_B = 10'h022;
   localparam logic [9:0] IDX_PULL_UP_SEL_C = 10'h024;
   localparam logic [9:0] IDX_PULL_UP_SEL_D = 10'h026;
   localparam logic [9:0] IDX_PULL_UP_SEL_H = 10'h02E;
   localparam logic [9:0] IDX_PULL_DOWN_SEL_A = 10'h030;
   localparam logic [9:0] IDX_PULL_DOWN_SEL_B = 10'h032;
   localparam logic [9:0] IDX_PULL_DOWN_SEL_C = 10'h034;
   localparam logic [9:0] IDX_PULL_DOWN_SEL_D = 10'h036;
   localparam logic [9:0] IDX_PULL_DOWN_SEL_H = 10'h03E;
   localparam logic [9:0] IDX_LATCH_CLEAR_A = 10'h070;
   localparam logic [9:0] IDX_LATCH_CLEAR_B = 10'h072;
   localparam logic [9:0] IDX_LATCH_CLEAR_C = 10'h074;
   localparam logic [9:0] IDX_LATCH_CLEAR_D = 10'h076;
   localparam logic [9:0] IDX_LATCH_CLEAR_H = 10'h07E;

   // ----------------------------------------
   // Implemented pin masks, port order A B C D H
   // ----------------------------------------
   localparam logic [15:0] MASK_A = 16'hFFFF;
   localparam logic [15:0] MASK_B = 16'hFFFF;
   localparam logic [15:0] MASK_C = 16'h7FFF;
   localparam logic [15:0] MASK_D = 16'h03FF;
   localparam logic [15:0] MASK_H = 16'h001F;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] RST_PULL_UP_A = 16'h6000;
   localparam logic [15:0] RST_PULL_UP_H = 16'h0001;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_LATCH = 16'h0000;

   // ----------------------------------------
   // Bus answers
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef logic [PORT_COUNT-1:0][PORT_WIDTH-1:0] plcps_word5_t;

   typedef struct packed {
      plcps_word5_t direction;
      plcps_word5_t open_drain;
      plcps_word5_t analog;
      plcps_word5_t alt_out;
   } plcps_mode_t;

   typedef struct packed {
      plcps_word5_t up;
      plcps_word5_t down;
   } plcps_pull_t;

   typedef enum logic [1:0] {
      PLCPS_GRP_NONE,
      PLCPS_GRP_UP,
      PLCPS_GRP_DOWN,
      PLCPS_GRP_CLEAR
   } plcps_group_t;

   localparam plcps_word5_t IMPL_MASK = {MASK_H, MASK_D, MASK_C, MASK_B, MASK_A};
   localparam plcps_word5_t RST_PULL_UP = {RST_PULL_UP_H, RST_ZERO, RST_ZERO, RST_ZERO,
                                           RST_PULL_UP_A};

endpackage : plcps_pkg

// File: rtl/plcps_top.sv
// Port latch clear and pull select block with AXI4-Lite register slave
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module plcps_top (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // AXI4-Lite slave
   input wire logic [plcps_pkg::ADDR_WIDTH-1:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [plcps_pkg::DATA_WIDTH-1:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [plcps_pkg::ADDR_WIDTH-1:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [plcps_pkg::DATA_WIDTH-1:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Port side
   input wire plcps_pkg::plcps_mode_t mode_in,
   input wire plcps_pkg::plcps_word5_t latch_set_in,
   output plcps_pkg::plcps_word5_t latch_out,
   output plcps_pkg::plcps_pull_t pull_en_out,
   output plcps_pkg::plcps_word5_t open_drain_drive_out,
   output plcps_pkg::plcps_word5_t output_buffer_on_out
);

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic void decode(input logic [9:0] idx, output plcps_pkg::plcps_group_t grp,
                                  output logic [2:0] port);
      grp = plcps_pkg::PLCPS_GRP_NONE;
      port = 3'h0;
      case (idx)
         plcps_pkg::IDX_PULL_UP_SEL_A: begin grp = plcps_pkg::PLCPS_GRP_UP; port = 3'h0; end
         plcps_pkg::IDX_PULL_UP_SEL_B: begin grp = plcps_pkg::PLCPS_GRP_UP; port = 3'h1; end
         plcps_pkg::IDX_PULL_UP_SEL_C: begin grp = plcps_pkg::PLCPS_GRP_UP; port = 3'h2; end
         plcps_pkg::IDX_PULL_UP_SEL_D: begin grp = plcps_pkg::PLCPS_GRP_UP; port = 3'h3; end
         plcps_pkg::IDX_PULL_UP_SEL_H: begin grp = plcps_pkg::PLCPS_GRP_UP; port = 3'h4; end
         plcps_pkg::IDX_PULL_DOWN_SEL_A: begin grp = plcps_pkg::PLCPS_GRP_DOWN; port = 3'h0; end
         plcps_pkg::IDX_PULL_DOWN_SEL_B: begin grp = plcps_pkg::PLCPS_GRP_DOWN; port = 3'h1; end
         plcps_pkg::IDX_PULL_DOWN_SEL_C: begin grp = plcps_pkg::PLCPS_GRP_DOWN; port = 3'h2; end
         plcps_pkg::IDX_PULL_DOWN_SEL_D: begin grp = plcps_pkg::PLCPS_GRP_DOWN; port = 3'h3; end
         plcps_pkg::IDX_PULL_DOWN_SEL_H: begin grp = plcps_pkg::PLCPS_GRP_DOWN; port = 3'h4; end
         plcps_pkg::IDX_LATCH_CLEAR_A: begin grp = plcps_pkg::PLCPS_GRP_CLEAR; port = 3'h0; end
         plcps_pkg::IDX_LATCH_CLEAR_B: begin grp = plcps_pkg::PLCPS_GRP_CLEAR; port = 3'h1; end
         plcps_pkg::IDX_LATCH_CLEAR_C: begin grp = plcps_pkg::PLCPS_GRP_CLEAR; port = 3'h2; end
         plcps_pkg::IDX_LATCH_CLEAR_D: begin grp = plcps_pkg::PLCPS_GRP_CLEAR; port = 3'h3; end
         plcps_pkg::IDX_LATCH_CLEAR_H: begin grp = plcps_pkg::PLCPS_GRP_CLEAR; port = 3'h4; end
         default: begin grp = plcps_pkg::PLCPS_GRP_NONE; port = 3'h0; end
      endcase
   endfunction : decode

   // ----------------------------------------
   // State
   // ----------------------------------------
   plcps_pkg::plcps_word5_t pull_up_sel;
   plcps_pkg::plcps_word5_t pull_down_sel;
   plcps_pkg::plcps_word5_t latch;
   logic aw_held;
   logic [9:0] aw_idx;
   logic w_held;
   logic [15:0] w_data;
   logic [1:0] w_strb;
   logic bvalid;
   logic [1:0] bresp;
   logic rvalid;
   logic [1:0] rresp;
   logic [15:0] rdata;

   plcps_pkg::plcps_word5_t next_pull_up_sel;
   plcps_pkg::plcps_word5_t next_pull_down_sel;
   plcps_pkg::plcps_word5_t next_latch;
   logic next_aw_held;
   logic [9:0] next_aw_idx;
   logic next_w_held;
   logic [15:0] next_w_data;
   logic [1:0] next_w_strb;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_rvalid;
   logic [1:0] next_rresp;
   logic [15:0] next_rdata;

   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic do_write;
   logic [9:0] wr_idx;
   logic [15:0] wr_data;
   logic [15:0] wr_bits;
   logic [1:0] wr_strb;
   plcps_pkg::plcps_group_t wr_grp;
   logic [2:0] wr_port;
   plcps_pkg::plcps_group_t rd_grp;
   logic [2:0] rd_port;
   plcps_pkg::plcps_word5_t clear_vec;

   // ----------------------------------------
   // Handshakes
   // ----------------------------------------
   assign s_axi_awready_out = ce_in & ~aw_held & ~bvalid;
   assign s_axi_wready_out = ce_in & ~w_held & ~bvalid;
   assign s_axi_arready_out = ce_in & ~rvalid;
   assign aw_fire = s_axi_awvalid_in & s_axi_awready_out;
   assign w_fire = s_axi_wvalid_in & s_axi_wready_out;
   assign ar_fire = s_axi_arvalid_in & s_axi_arready_out;
   assign s_axi_bvalid_out = bvalid;
   assign s_axi_bresp_out = bresp;
   assign s_axi_rvalid_out = rvalid;
   assign s_axi_rresp_out = rresp;
   assign s_axi_rdata_out = {16'h0000, rdata};

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      wr_idx = aw_held ? aw_idx : s_axi_awaddr_in[11:2];
      wr_data = w_held ? w_data : s_axi_wdata_in[15:0];
      wr_strb = w_held ? w_strb : s_axi_wstrb_in[1:0];
      wr_bits = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
      do_write = ce_in & ~bvalid & (aw_held | aw_fire) & (w_held | w_fire);
      decode(wr_idx, wr_grp, wr_port);
      decode(s_axi_araddr_in[11:2], rd_grp, rd_port);

      next_pull_up_sel = pull_up_sel;
      next_pull_down_sel = pull_down_sel;
      clear_vec = '0;
      next_aw_held = aw_held;
      next_aw_idx = aw_idx;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;

      if (aw_fire) begin
         next_aw_held = 1'b1;
         next_aw_idx = s_axi_awaddr_in[11:2];
      end
      if (w_fire) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata_in[15:0];
         next_w_strb = s_axi_wstrb_in[1:0];
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = plcps_pkg::RESP_OKAY;
         case (wr_grp)
            plcps_pkg::PLCPS_GRP_UP: begin
               next_pull_up_sel[wr_port] = ((pull_up_sel[wr_port] & ~wr_bits)
                  | (wr_data & wr_bits)) & plcps_pkg::IMPL_MASK[wr_port];
            end
            plcps_pkg::PLCPS_GRP_DOWN: begin
               next_pull_down_sel[wr_port] = ((pull_down_sel[wr_port] & ~wr_bits)
                  | (wr_data & wr_bits)) & plcps_pkg::IMPL_MASK[wr_port];
            end
            plcps_pkg::PLCPS_GRP_CLEAR: begin
               clear_vec[wr_port] = wr_data & wr_bits & plcps_pkg::IMPL_MASK[wr_port];
            end
            default: begin
               next_bresp = plcps_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (bvalid & s_axi_bready_in) begin
         next_bvalid = 1'b0;
      end

      if (ar_fire) begin
         next_rvalid = 1'b1;
         next_rresp = plcps_pkg::RESP_OKAY;
         case (rd_grp)
            plcps_pkg::PLCPS_GRP_UP: begin
               next_rdata = pull_up_sel[rd_port];
            end
            plcps_pkg::PLCPS_GRP_DOWN: begin
               next_rdata = pull_down_sel[rd_port];
            end
            plcps_pkg::PLCPS_GRP_CLEAR: begin
               next_rdata = 16'h0000;
            end
            default: begin
               next_rdata = 16'h0000;
               next_rresp = plcps_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid & s_axi_rready_in) begin
         next_rvalid = 1'b0;
      end

      next_latch = ((latch | latch_set_in) & ~clear_vec) & plcps_pkg::IMPL_MASK;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pull_up_sel <= plcps_pkg::RST_PULL_UP;
         pull_down_sel <= '0;
         latch <= '0;
         aw_held <= 1'b0;
         aw_idx <= 10'h000;
         w_held <= 1'b0;
         w_data <= 16'h0000;
         w_strb <= 2'h0;
         bvalid <= 1'b0;
         bresp <= plcps_pkg::RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= plcps_pkg::RESP_OKAY;
         rdata <= 16'h0000;
      end else if (ce_in) begin
         pull_up_sel <= next_pull_up_sel;
         pull_down_sel <= next_pull_down_sel;
         latch <= next_latch;
         aw_held <= next_aw_held;
         aw_idx <= next_aw_idx;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Pin controls
   // ----------------------------------------
   plcps_pkg::plcps_word5_t gate_off;
   assign gate_off = mode_in.alt_out | mode_in.analog;
   assign latch_out = latch;
   assign output_buffer_on_out = ~mode_in.direction & plcps_pkg::IMPL_MASK;
   assign open_drain_drive_out = ~mode_in.direction & mode_in.open_drain
                                 & plcps_pkg::IMPL_MASK;
   assign pull_en_out.up = pull_up_sel & (mode_in.direction | mode_in.open_drain)
                           & ~gate_off;
   assign pull_en_out.down = pull_down_sel & mode_in.direction & ~gate_off;

endmodule : plcps_top

`default_nettype wire

// File: sim/plcps_checker.sv
// Checker of bus answers, latch clearing and pull gating
`timescale 1ns/1ps
`default_nettype none

module plcps_checker (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [11:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bvalid_out,
   input wire logic [11:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic s_axi_rvalid_out,
   input wire plcps_pkg::plcps_mode_t mode_in,
   input wire plcps_pkg::plcps_word5_t latch_out,
   input wire plcps_pkg::plcps_pull_t pull_en_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   sequence s_wr_take;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
   endsequence
   sequence s_clr_a;
      s_wr_take ##0 (s_axi_awaddr_in == 12'h1C0 && s_axi_wstrb_in[1:0] == 2'h3);
   endsequence
   property p_clear;
      s_clr_a |=> s_axi_bvalid_out && (latch_out[0] & $past(s_axi_wdata_in[15:0])) == 16'h0000;
   endproperty
   property p_unmapped;
      s_wr_take ##0 (s_axi_awaddr_in == 12'h004) |=>
         s_axi_bvalid_out && s_axi_bresp_out == plcps_pkg::RESP_SLVERR;
   endproperty
   property p_clr_read;
      s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[11:6] == 6'h07 |=>
         s_axi_rvalid_out && s_axi_rdata_out == 32'h0000_0000;
   endproperty
   property p_pu_mode;
      (pull_en_out.up & ~(mode_in.direction | mode_in.open_drain)) == '0;
   endproperty
   property p_pu_off;
      (pull_en_out.up & (mode_in.alt_out | mode_in.analog)) == '0;
   endproperty
   property p_pd_mode;
      (pull_en_out.down & ~mode_in.direction) == '0;
   endproperty
   property p_pd_off;
      (pull_en_out.down & (mode_in.alt_out | mode_in.analog)) == '0;
   endproperty
   property p_impl;
      ((latch_out | pull_en_out.up | pull_en_out.down) & ~plcps_pkg::IMPL_MASK) == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("clear left latch bit set");
   a_unmapped: assert property (p_unmapped) else $error("unmapped write not refused");
   a_clr_read: assert property (p_clr_read) else $error("clear register read not zero");
   a_pu_mode: assert property (p_pu_mode) else $error("pull-up on in push-pull");
   a_pu_off: assert property (p_pu_off) else $error("pull-up on in alt or analog");
   a_pd_mode: assert property (p_pd_mode) else $error("pull-down on in output");
   a_pd_off: assert property (p_pd_off) else $error("pull-down on in alt or analog");
   a_impl: assert property (p_impl) else $error("unimplemented bit active");
endmodule : plcps_checker

bind plcps_top plcps_checker chk_u (.*);

`default_nettype wire

// File: sim/plcps_top_bench.sv
// Testbench of the port latch clear and pull select block
`timescale 1ns/1ps
`default_nettype none

module plcps_top_bench;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic ce_in = 1'b1;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic bready = 1'b1, rready = 1'b1;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   plcps_pkg::plcps_mode_t mode = '0;
   plcps_pkg::plcps_word5_t lset = '0;
   plcps_pkg::plcps_word5_t latch, odd, obuf, eup, edn, el;
   plcps_pkg::plcps_pull_t pull;
   logic [9:0] offs [5] = '{10'h000, 10'h002, 10'h004, 10'h006, 10'h00E};
   int n_mismatch = 0;
   int total_checks = 0;

   always #12.5 clk_in = ~clk_in;

   plcps_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .mode_in(mode),
      .latch_set_in(lset), .latch_out(latch), .pull_en_out(pull),
      .open_drain_drive_out(odd), .output_buffer_on_out(obuf));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      awaddr <= {idx, 2'b00};
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!done && n < 100) begin
         @(posedge clk_in);
         n++;
         if (awready && awvalid) awvalid <= 1'b0;
         if (wready && wvalid) wvalid <= 1'b0;
         if (bvalid) begin
            done = 1'b1;
            chk(bresp, er, "bresp");
         end
      end
      if (!done) chk(80'h0, 80'h1, "write hang");
   endtask : wr

   task automatic rd(input logic [9:0] idx, input logic [15:0] ed, input logic [1:0] er);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      while (!done && n < 100) begin
         @(posedge clk_in);
         n++;
         if (arready && arvalid) arvalid <= 1'b0;
         if (rvalid) begin
            done = 1'b1;
            chk(rdata, {16'h0000, ed}, "rdata");
            chk(rresp, er, "rresp");
         end
      end
      if (!done) chk(80'h0, 80'h1, "read hang");
   endtask : rd

   task automatic pins();
      @(posedge clk_in);
      chk(pull.up, eup & (mode.direction | mode.open_drain) & ~(mode.alt_out | mode.analog),
         "up");
      chk(pull.down, edn & mode.direction & ~(mode.alt_out | mode.analog), "down");
      chk(odd, ~mode.direction & mode.open_drain & plcps_pkg::IMPL_MASK, "od");
      chk(obuf, ~mode.direction & plcps_pkg::IMPL_MASK, "obuf");
   endtask : pins

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      eup = plcps_pkg::RST_PULL_UP;
      edn = '0;
      pins();
      for (int p = 0; p < 5; p++) begin
         rd(10'h020 + offs[p], plcps_pkg::RST_PULL_UP[p], plcps_pkg::RESP_OKAY);
         rd(10'h030 + offs[p], 16'h0000, plcps_pkg::RESP_OKAY);
         rd(10'h070 + offs[p], 16'h0000, plcps_pkg::RESP_OKAY);
      end
      rd(10'h001, 16'h0000, plcps_pkg::RESP_SLVERR);
      wr(10'h001, 16'hFFFF, plcps_pkg::RESP_SLVERR);
      for (int s = 0; s < 2; s++) begin
         for (int p = 0; p < 5; p++) begin
            wr(10'h020 + offs[p], {16{s[0]}} ^ 16'hFFFF, plcps_pkg::RESP_OKAY);
            rd(10'h020 + offs[p], plcps_pkg::IMPL_MASK[p] & ~{16{s[0]}}, 2'h0);
            wr(10'h030 + offs[p], {16{s[0]}} ^ 16'hFFFF, plcps_pkg::RESP_OKAY);
            rd(10'h030 + offs[p], plcps_pkg::IMPL_MASK[p] & ~{16{s[0]}}, 2'h0);
         end
         eup = plcps_pkg::IMPL_MASK & ~{80{s[0]}};
         edn = eup;
         mode <= '{direction: {5{16'hFF00}}, open_drain: {5{16'hF0F0}},
                   alt_out: {5{16'hCCCC}}, analog: {5{16'hAAAA}}};
         pins();
         mode <= '{direction: {5{16'h00FF}}, open_drain: {5{16'h0F0F}},
                   alt_out: '0, analog: '0};
         pins();
      end
      lset <= '1;
      @(posedge clk_in);
      lset <= '0;
      @(posedge clk_in);
      el = plcps_pkg::IMPL_MASK;
      chk(latch, el, "latch set");
      for (int p = 0; p < 5; p++) begin
         wr(10'h070 + offs[p], 16'h0FF0 >> p, plcps_pkg::RESP_OKAY);
         el[p] = el[p] & ~(16'h0FF0 >> p);
         chk(latch, el, "latch clear");
         rd(10'h070 + offs[p], 16'h0000, plcps_pkg::RESP_OKAY);
      end
      lset <= '1;
      wr(10'h070, 16'hFFFF, plcps_pkg::RESP_OKAY);
      chk(latch[0], 16'h0000, "clear wins");
      lset <= '0;
      ce_in <= 1'b0;
      @(posedge clk_in);
      chk(awready, 1'b0, "frozen awready");
      chk(arready, 1'b0, "frozen arready");
      chk(latch, plcps_pkg::IMPL_MASK, "frozen latch");
      rst_in <= 1'b1;
      @(posedge clk_in);
      rst_in <= 1'b0;
      ce_in <= 1'b1;
      @(posedge clk_in);
      chk(latch, 80'h0, "latch after reset");
      rd(10'h020, plcps_pkg::RST_PULL_UP_A, plcps_pkg::RESP_OKAY);
      rd(10'h02E, plcps_pkg::RST_PULL_UP_H, plcps_pkg::RESP_OKAY);
      wstrb <= 4'h1;
      wr(10'h032, 16'hFFFF, plcps_pkg::RESP_OKAY);
      rd(10'h032, 16'h00FF, plcps_pkg::RESP_OKAY);
      wstrb <= 4'hF;
      report_and_stop();
   end

   initial begin
      #(25 * 5000);
      n_mismatch++;
      report_and_stop();
   end
endmodule : plcps_top_bench

`default_nettype wire
